// File: rtl/rf_frame_crc_config.v
// Purpose: CRC append and check for a contactless reader frontend
// Assumes: Framing logic on clk marks frame start, bits and end
// Notes:   Setup is latched at each frame start
// Functional notes
// R01 - Tx enable appends CRC to outgoing frame
// R02 - Tx invert flips CRC bits before appending
// R03 - Width code: 0 CRC5, 1 CRC8, 2 CRC16
// R04 - CRC16 start values by select code
// R05 - CRC8 start values by select code
// R06 - CRC5 start values: codes 0, 1, 7
// R07 - Code 6 uses user value; 4,5 undefined
// R08 - Rx to-FIFO bit forwards received CRC bits
// R09 - Software sets to-FIFO for unaligned CRC
// R10 - Rx invert checks against inverted CRC
// R11 - Rx enable checks, flags error on mismatch
// R12 - Rx disabled: compute, leave error untouched
// R13 - Rx start select uses same code table
// R14 - Reload start value at each frame start
// R15 - Tx bit 7 ignores writes, reads zero
`timescale 1ns/1ps
`include "rf_crc_defines.vh"

module rf_frame_crc_config (
    // Clock and reset
    input  wire        clk,
    input  wire        srst,
    // Register port
    input  wire [7:0]  addr,
    input  wire [7:0]  wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [7:0]  rdata,
    // Non-volatile user start value
    input  wire [15:0] user_preset,
    // Transmit framing side
    input  wire        tx_frame_start,
    input  wire        tx_bit_valid,
    input  wire        tx_bit,
    input  wire        tx_frame_end,
    input  wire        tx_out_ready,
    output reg         tx_crc_valid,
    output reg         tx_crc_bit,
    output reg         tx_crc_done,
    // Receive framing side
    input  wire        rx_frame_start,
    input  wire        rx_bit_valid,
    input  wire        rx_bit,
    input  wire        rx_crc_field,
    input  wire        rx_frame_end,
    output reg         rx_fifo_valid,
    output reg         rx_fifo_bit,
    output reg         rx_check_done,
    output reg         rx_crc_error,
    // Interrupt
    output reg         irq
);

    localparam TX_IDLE   = 2'b00;
    localparam TX_DATA   = 2'b01;
    localparam TX_APPEND = 2'b10;

    // Setup registers and interrupt state
    reg [7:0]  tx_setup_reg;
    reg [7:0]  rx_setup_reg;
    reg [2:0]  irq_status_reg;
    reg [2:0]  irq_enable_reg;

    // Transmit state
    reg [1:0]  tx_state_reg;
    reg [1:0]  tx_width_reg;
    reg        tx_append_reg;
    reg        tx_invert_reg;
    reg [15:0] tx_shift_reg;
    reg [4:0]  tx_count_reg;

    // Receive state
    reg        rx_active_reg;
    reg [1:0]  rx_width_reg;
    reg        rx_check_reg;
    reg        rx_invert_reg;
    reg        rx_to_fifo_reg;
    reg [15:0] rx_capture_reg;
    reg [4:0]  rx_count_reg;

    wire [15:0] tx_preset;
    wire [15:0] rx_preset;
    wire [15:0] tx_crc_value;
    wire [15:0] rx_crc_value;

    wire        tx_load;
    wire        tx_feed;
    wire        rx_load;
    wire        rx_feed;
    reg         tx_done_evt;
    reg         rx_ok_evt;
    reg         rx_err_evt;
    reg  [15:0] rx_expected;
    reg         rx_match;

    function [15:0] width_mask;
        input [1:0] w;
        begin
            case (w)
                `W_CRC5:  width_mask = 16'h001F;
                `W_CRC8:  width_mask = 16'h00FF;
                `W_CRC16: width_mask = 16'hFFFF;
                default:  width_mask = 16'h0000;
            endcase
        end
    endfunction

    function [4:0] width_bits;
        input [1:0] w;
        begin
            case (w)
                `W_CRC5:  width_bits = 5'h05;
                `W_CRC8:  width_bits = 5'h08;
                `W_CRC16: width_bits = 5'h10;
                default:  width_bits = 5'h00;
            endcase
        end
    endfunction

    // Left-aligns the CRC so the first bit out is always bit 15
    function [15:0] align_top;
        input [15:0] c;
        input [1:0]  w;
        begin
            case (w)
                `W_CRC5:  align_top = {c[4:0], 11'h000};
                `W_CRC8:  align_top = {c[7:0], 8'h00};
                default:  align_top = c;
            endcase
        end
    endfunction

    // Start values from the live setup, both directions share one table
    crc_preset_lookup u_tx_preset (
        .start_sel   (tx_setup_reg[`F_START_HI:`F_START_LO]),
        .width_sel   (tx_setup_reg[`F_WIDTH_HI:`F_WIDTH_LO]),
        .user_preset (user_preset),
        .preset      (tx_preset)
    ); // [R03] [R04] [R05] [R06] [R07]

    crc_preset_lookup u_rx_preset (
        .start_sel   (rx_setup_reg[`F_START_HI:`F_START_LO]),
        .width_sel   (rx_setup_reg[`F_WIDTH_HI:`F_WIDTH_LO]),
        .user_preset (user_preset),
        .preset      (rx_preset)
    ); // [R13]

    assign tx_load = tx_frame_start;
    assign tx_feed = tx_bit_valid && (tx_state_reg == TX_DATA);
    assign rx_load = rx_frame_start;
    assign rx_feed = rx_bit_valid && rx_active_reg && !rx_crc_field;

    // Reload on each frame start, before any data bit
    crc_bit_engine u_tx_engine (
        .clk       (clk),
        .srst      (srst),
        .load      (tx_load),
        .preset    (tx_preset),
        .width_sel (tx_width_reg),
        .bit_valid (tx_feed),
        .bit_in    (tx_bit),
        .crc_reg   (tx_crc_value)
    ); // [R14]

    // Receive CRC runs whether or not checking is on
    crc_bit_engine u_rx_engine (
        .clk       (clk),
        .srst      (srst),
        .load      (rx_load),
        .preset    (rx_preset),
        .width_sel (rx_width_reg),
        .bit_valid (rx_feed),
        .bit_in    (rx_bit),
        .crc_reg   (rx_crc_value)
    ); // [R12] [R14]

    // Setup registers
    always @(posedge clk) begin
        if (srst) begin
            tx_setup_reg   <= `TX_SETUP_RESET;
            rx_setup_reg   <= `RX_SETUP_RESET;
            irq_enable_reg <= `IRQ_ENABLE_RESET;
        end else if (wr) begin
            if (addr == `REG_TX_SETUP) begin
                tx_setup_reg <= wdata & `TX_SETUP_MASK; // [R15]
            end else if (addr == `REG_RX_SETUP) begin
                rx_setup_reg <= wdata;
            end else if (addr == `REG_IRQ_ENABLE) begin
                irq_enable_reg <= wdata[2:0];
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            if (addr == `REG_TX_SETUP) begin
                rdata <= tx_setup_reg; // [R15]
            end else if (addr == `REG_RX_SETUP) begin
                rdata <= rx_setup_reg;
            end else if (addr == `REG_IRQ_STATUS) begin
                rdata <= {5'h00, irq_status_reg};
            end else if (addr == `REG_IRQ_ENABLE) begin
                rdata <= {5'h00, irq_enable_reg};
            end else if (addr == `REG_RX_CRC_LO) begin
                rdata <= rx_crc_value[7:0];
            end else if (addr == `REG_RX_CRC_HI) begin
                rdata <= rx_crc_value[15:8];
            end else begin
                rdata <= 8'h00;
            end
        end else begin
            rdata <= 8'h00;
        end
    end

    // Transmit sequence: data, then optional appended CRC
    always @(posedge clk) begin
        if (srst) begin
            tx_state_reg  <= TX_IDLE;
            tx_width_reg  <= `W_CRC5;
            tx_append_reg <= 1'b0;
            tx_invert_reg <= 1'b0;
            tx_shift_reg  <= 16'h0000;
            tx_count_reg  <= 5'h00;
            tx_crc_valid  <= 1'b0;
            tx_crc_bit    <= 1'b0;
            tx_crc_done   <= 1'b0;
        end else begin
            tx_crc_valid <= 1'b0;
            tx_crc_done  <= 1'b0;
            if (tx_frame_start) begin
                // Settings are frozen per frame so a mid-frame write cannot corrupt it
                tx_state_reg  <= TX_DATA;
                tx_width_reg  <= tx_setup_reg[`F_WIDTH_HI:`F_WIDTH_LO];
                tx_append_reg <= tx_setup_reg[`F_ENABLE];
                tx_invert_reg <= tx_setup_reg[`F_INVERT];
            end else begin
                case (tx_state_reg)
                    TX_DATA: begin
                        if (tx_frame_end) begin
                            if (tx_append_reg) begin
                                tx_state_reg <= TX_APPEND; // [R01]
                                tx_count_reg <= width_bits(tx_width_reg);
                                tx_shift_reg <= align_top(tx_crc_value ^
                                    (tx_invert_reg ? width_mask(tx_width_reg) : 16'h0000),
                                    tx_width_reg); // [R02]
                            end else begin
                                tx_state_reg <= TX_IDLE;
                                tx_crc_done  <= 1'b1;
                            end
                        end
                    end
                    TX_APPEND: begin
                        if (tx_count_reg == 5'h00) begin
                            tx_state_reg <= TX_IDLE;
                            tx_crc_done  <= 1'b1;
                        end else if (tx_out_ready) begin
                            tx_crc_valid <= 1'b1; // [R01]
                            tx_crc_bit   <= tx_shift_reg[15];
                            tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
                            tx_count_reg <= tx_count_reg - 5'h01;
                        end
                    end
                    default: tx_state_reg <= TX_IDLE;
                endcase
            end
        end
    end

    // Receive comparison, computed at frame end
    always @* begin
        rx_expected = (rx_crc_value ^ (rx_invert_reg ? width_mask(rx_width_reg) : 16'h0000))
                      & width_mask(rx_width_reg); // [R10]
        rx_match    = ((rx_capture_reg & width_mask(rx_width_reg)) == rx_expected) &&
                      (rx_count_reg == width_bits(rx_width_reg)) &&
                      (width_bits(rx_width_reg) != 5'h00);
    end

    // Receive sequence: data into engine, CRC field captured for the check
    always @(posedge clk) begin
        if (srst) begin
            rx_active_reg  <= 1'b0;
            rx_width_reg   <= `W_CRC5;
            rx_check_reg   <= 1'b0;
            rx_invert_reg  <= 1'b0;
            rx_to_fifo_reg <= 1'b0;
            rx_capture_reg <= 16'h0000;
            rx_count_reg   <= 5'h00;
            rx_fifo_valid  <= 1'b0;
            rx_fifo_bit    <= 1'b0;
            rx_check_done  <= 1'b0;
            rx_crc_error   <= 1'b0;
        end else begin
            rx_fifo_valid <= 1'b0;
            rx_check_done <= 1'b0;
            rx_crc_error  <= 1'b0;
            if (rx_frame_start) begin
                rx_active_reg  <= 1'b1;
                rx_width_reg   <= rx_setup_reg[`F_WIDTH_HI:`F_WIDTH_LO];
                rx_check_reg   <= rx_setup_reg[`F_ENABLE];
                rx_invert_reg  <= rx_setup_reg[`F_INVERT];
                rx_to_fifo_reg <= rx_setup_reg[`F_TO_FIFO];
                rx_capture_reg <= 16'h0000;
                rx_count_reg   <= 5'h00;
            end else if (rx_active_reg) begin
                if (rx_frame_end) begin
                    rx_active_reg <= 1'b0;
                    rx_check_done <= 1'b1;
                    // Flag only when checking is on; otherwise it stays low
                    rx_crc_error  <= rx_check_reg && !rx_match; // [R11] [R12]
                end else if (rx_bit_valid && rx_crc_field) begin
                    rx_capture_reg <= {rx_capture_reg[14:0], rx_bit};
                    if (rx_count_reg != 5'h1F) begin
                        rx_count_reg <= rx_count_reg + 5'h01;
                    end
                    // Per-bit forwarding keeps a non byte aligned CRC intact
                    rx_fifo_valid <= rx_to_fifo_reg; // [R08] [R09]
                    rx_fifo_bit   <= rx_bit;
                end
            end
        end
    end

    // Interrupt events
    always @* begin
        tx_done_evt = ((tx_state_reg == TX_APPEND) && (tx_count_reg == 5'h00) && !tx_frame_start) ||
                      ((tx_state_reg == TX_DATA) && tx_frame_end && !tx_append_reg && !tx_frame_start);
        rx_ok_evt   = rx_active_reg && !rx_frame_start && rx_frame_end && rx_check_reg && rx_match;
        rx_err_evt  = rx_active_reg && !rx_frame_start && rx_frame_end && rx_check_reg && !rx_match;
    end

    // Sticky status: a new event wins over a clear in the same cycle
    always @(posedge clk) begin
        if (srst) begin
            irq_status_reg <= 3'h0;
            irq            <= 1'b0;
        end else begin
            irq_status_reg <= (irq_status_reg &
                               ~((wr && (addr == `REG_IRQ_CLEAR)) ? wdata[2:0] : 3'h0)) |
                              {rx_err_evt, rx_ok_evt, tx_done_evt};
            irq            <= |(irq_status_reg & irq_enable_reg);
        end
    end

endmodule

// File: include/rf_crc_defines.vh
// Purpose: Constants for the frame CRC configuration block
// Assumes: Included by its bare name from every design file
// Notes:   Definitions only
`ifndef RF_CRC_DEFINES_VH
`define RF_CRC_DEFINES_VH

// Register offsets
`define REG_TX_SETUP     8'h2C
`define REG_RX_SETUP     8'h2D
`define REG_IRQ_STATUS   8'h40
`define REG_IRQ_ENABLE   8'h41
`define REG_IRQ_CLEAR    8'h42
`define REG_RX_CRC_LO    8'h43
`define REG_RX_CRC_HI    8'h44

// Reset values and tx setup write mask
`define TX_SETUP_RESET   8'h00
`define RX_SETUP_RESET   8'h00
`define IRQ_ENABLE_RESET 3'h0
`define TX_SETUP_MASK    8'h7F

// Field positions; all but F_TO_FIFO shared by both setup registers
`define F_ENABLE         0
`define F_INVERT         1
`define F_WIDTH_LO       2
`define F_WIDTH_HI       3
`define F_START_LO       4
`define F_START_HI       6
`define F_TO_FIFO        7

// Width select codes
`define W_CRC5           2'h0
`define W_CRC8           2'h1
`define W_CRC16          2'h2

// Start value select codes
`define S_ZERO           3'h0
`define S_ONE            3'h1
`define S_TWO            3'h2
`define S_THREE          3'h3
`define S_USER           3'h6
`define S_ALL            3'h7

// Start values
`define P16_ONE          16'h6363
`define P16_TWO          16'hA671
`define P16_THREE        16'hFFFE
`define P16_ALL          16'hFFFF
`define P8_ONE           8'h12
`define P8_TWO           8'hBF
`define P8_THREE         8'hFD
`define P8_ALL           8'hFF
`define P5_ONE           5'h12
`define P5_ALL           5'h1F

// Generator polynomials, top bit implied
`define POLY16           16'h1021
`define POLY8            8'h1D
`define POLY5            5'h09

// Interrupt status bits
`define IRQ_TX_DONE      0
`define IRQ_RX_OK        1
`define IRQ_RX_ERR       2

`endif

// File: rtl/crc_preset_lookup.v
// Purpose: Maps a start value select code to a CRC start value
// Assumes: User value comes from non-volatile configuration
// Notes:   Undefined codes give zero
`timescale 1ns/1ps
`include "rf_crc_defines.vh"

module crc_preset_lookup (
    // Selection
    input  wire [2:0]  start_sel,
    input  wire [1:0]  width_sel,
    // Non-volatile user value
    input  wire [15:0] user_preset,
    // Result
    output reg  [15:0] preset
);

    always @* begin
        preset = 16'h0000;
        case (width_sel)
            `W_CRC16: begin
                case (start_sel)
                    `S_ONE:   preset = `P16_ONE;
                    `S_TWO:   preset = `P16_TWO;
                    `S_THREE: preset = `P16_THREE;
                    `S_USER:  preset = user_preset;
                    `S_ALL:   preset = `P16_ALL;
                    default:  preset = 16'h0000;
                endcase
            end
            `W_CRC8: begin
                case (start_sel)
                    `S_ONE:   preset = {8'h00, `P8_ONE};
                    `S_TWO:   preset = {8'h00, `P8_TWO};
                    `S_THREE: preset = {8'h00, `P8_THREE};
                    `S_USER:  preset = {8'h00, user_preset[7:0]};
                    `S_ALL:   preset = {8'h00, `P8_ALL};
                    default:  preset = 16'h0000;
                endcase
            end
            `W_CRC5: begin
                case (start_sel)
                    `S_ONE:   preset = {11'h000, `P5_ONE};
                    `S_USER:  preset = {11'h000, user_preset[4:0]};
                    `S_ALL:   preset = {11'h000, `P5_ALL};
                    default:  preset = 16'h0000;
                endcase
            end
            default: preset = 16'h0000;
        endcase
    end

endmodule

// File: rtl/crc_bit_engine.v
// Purpose: Serial CRC register, one bit per accepted cycle
// Assumes: Bits arrive most significant first into the shift
// Notes:   Load has priority over a bit in the same cycle
`timescale 1ns/1ps
`include "rf_crc_defines.vh"

module crc_bit_engine (
    // Clock and reset
    input  wire        clk,
    input  wire        srst,
    // Control
    input  wire        load,
    input  wire [15:0] preset,
    input  wire [1:0]  width_sel,
    // Data bits
    input  wire        bit_valid,
    input  wire        bit_in,
    // Running value
    output reg  [15:0] crc_reg
);

    function [15:0] crc_step;
        input [15:0] c;
        input [1:0]  w;
        input        b;
        reg          fb;
        begin
            fb = 1'b0;
            case (w)
                `W_CRC5: begin
                    fb = c[4] ^ b;
                    crc_step = {11'h000, c[3:0], 1'b0} ^ (fb ? {11'h000, `POLY5} : 16'h0000);
                end
                `W_CRC8: begin
                    fb = c[7] ^ b;
                    crc_step = {8'h00, c[6:0], 1'b0} ^ (fb ? {8'h00, `POLY8} : 16'h0000);
                end
                `W_CRC16: begin
                    fb = c[15] ^ b;
                    crc_step = {c[14:0], 1'b0} ^ (fb ? `POLY16 : 16'h0000);
                end
                default: crc_step = c;
            endcase
        end
    endfunction

    always @(posedge clk) begin
        if (srst) begin
            crc_reg <= 16'h0000;
        end else if (load) begin
            crc_reg <= preset;
        end else if (bit_valid) begin
            crc_reg <= crc_step(crc_reg, width_sel, bit_in);
        end
    end

endmodule

// File: dv/rf_crc_checker.sv
// Purpose: Port assertions for the frame CRC block
// Assumes: Single clock, srst disables every check
// Notes:   Bound to the top module below
`timescale 1ns/1ps
module rf_crc_checker (
    // Clock and reset
    input wire       clk,
    input wire       srst,
    // Register port
    input wire [7:0] addr,
    input wire       rd,
    input wire [7:0] rdata,
    // Transmit side
    input wire       tx_frame_end,
    input wire       tx_out_ready,
    input wire       tx_crc_valid,
    input wire       tx_crc_done,
    // Receive side
    input wire       rx_bit_valid,
    input wire       rx_bit,
    input wire       rx_crc_field,
    input wire       rx_frame_end,
    input wire       rx_fifo_valid,
    input wire       rx_fifo_bit,
    input wire       rx_check_done,
    input wire       rx_crc_error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_rd_tx;
        rd && addr == 8'h2C;
    endsequence
    sequence s_crc_in;
        rx_bit_valid && rx_crc_field;
    endsequence
    // Slow pacing stretches a 16 bit append to about 64 cycles
    a_tx_reserved_bit: assert property (s_rd_tx |=> !rdata[7])
        else $error("tx setup bit 7 read set");
    a_tx_paced_out: assert property (tx_crc_valid |-> $past(tx_out_ready))
        else $error("tx bit without ready");
    a_tx_done_bound: assert property (tx_frame_end |-> ##[1:100] tx_crc_done)
        else $error("tx done missing");
    a_tx_done_pulse: assert property (tx_crc_done |=> !tx_crc_done)
        else $error("tx done too long");
    a_rx_done_next: assert property (rx_frame_end |=> rx_check_done)
        else $error("rx done late");
    a_rx_err_done: assert property (rx_crc_error |-> rx_check_done)
        else $error("rx error alone");
    a_fifo_from_crc: assert property (rx_fifo_valid |-> $past(rx_bit_valid && rx_crc_field))
        else $error("fifo bit not from crc");
    a_fifo_bit_copy: assert property (s_crc_in ##1 rx_fifo_valid |-> rx_fifo_bit == $past(rx_bit))
        else $error("fifo bit wrong");
endmodule

bind rf_frame_crc_config rf_crc_checker chk_u (.clk, .srst, .addr, .rd, .rdata, .tx_frame_end,
    .tx_out_ready, .tx_crc_valid, .tx_crc_done, .rx_bit_valid, .rx_bit, .rx_crc_field,
    .rx_frame_end, .rx_fifo_valid, .rx_fifo_bit, .rx_check_done, .rx_crc_error);

// File: dv/rf_tag_model.sv
// Purpose: Transponder model: sends frames, paces appended bits
// Assumes: Bench calls send between frames only
// Notes:   Idle data line shows the inverse of its last bit
`timescale 1ns/1ps
module rf_tag_model (
    // Clock and pacing
    input  wire  clk,
    input  wire  slow,
    // Frames into the block
    output logic rx_frame_start,
    output logic rx_bit_valid,
    output logic rx_bit,
    output logic rx_crc_field,
    output logic rx_frame_end,
    // Append pacing
    output logic tx_out_ready
);
    logic [1:0] pace = 2'h0;
    initial begin
        {rx_frame_start, rx_bit_valid, rx_bit, rx_crc_field, rx_frame_end} = 5'h00;
        tx_out_ready = 1'b0;
    end
    // Slow mode takes an appended bit in one cycle of four
    always @(posedge clk) begin
        pace <= pace + 2'h1;
        tx_out_ready <= !slow || pace == 2'h0;
    end
    task send(input [23:0] f, input int n, input int nc);
        int i;
        @(posedge clk);
        rx_frame_start <= 1'b1;
        for (i = n - 1; i >= 0; i--) begin
            @(posedge clk);
            rx_frame_start <= 1'b0;
            rx_bit_valid <= 1'b1;
            rx_bit <= f[i];
            rx_crc_field <= i < nc;
        end
        @(posedge clk);
        rx_bit_valid <= 1'b0;
        rx_bit <= ~f[0];
        rx_crc_field <= 1'b0;
        rx_frame_end <= 1'b1;
        @(posedge clk);
        rx_frame_end <= 1'b0;
    endtask
endmodule

// File: dv/rf_frame_crc_config_tb_top.sv
// Purpose: Self-checking bench for the frame CRC block
// Assumes: Tag model paces tx bits and sends rx frames
// Notes:   Expected CRCs come from a bit-serial model here
`timescale 1ns/1ps
module rf_frame_crc_config_tb_top;
    logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, rd_q = 1'b0, slow = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rnd = 8'h42;
    logic [15:0] user_preset = 16'h0000;
    logic        tx_frame_start = 1'b0, tx_bit_valid = 1'b0, tx_bit = 1'b0, tx_frame_end = 1'b0;
    wire  [7:0]  rdata;
    wire         tx_out_ready, tx_crc_valid, tx_crc_bit, tx_crc_done, irq;
    wire         rx_frame_start, rx_bit_valid, rx_bit, rx_crc_field, rx_frame_end;
    wire         rx_fifo_valid, rx_fifo_bit, rx_check_done, rx_crc_error;
    logic [7:0]  rq[$];
    logic        txq[$], eq[$], fq[$];
    int          fails = 0, compares = 0;
    always #50 clk = ~clk;
    rf_frame_crc_config dut_u (.clk, .srst, .addr, .wdata, .wr, .rd, .rdata, .user_preset,
        .tx_frame_start, .tx_bit_valid, .tx_bit, .tx_frame_end, .tx_out_ready, .tx_crc_valid,
        .tx_crc_bit, .tx_crc_done, .rx_frame_start, .rx_bit_valid, .rx_bit, .rx_crc_field,
        .rx_frame_end, .rx_fifo_valid, .rx_fifo_bit, .rx_check_done, .rx_crc_error, .irq);
    rf_tag_model p_u (.clk, .slow, .rx_frame_start, .rx_bit_valid, .rx_bit, .rx_crc_field,
        .rx_frame_end, .tx_out_ready);

    function automatic [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic int nb(input [1:0] w);
        nb = w == 2'h2 ? 16 : w == 2'h1 ? 8 : 5;
    endfunction
    function automatic [15:0] msk(input [1:0] w);
        msk = w == 2'h2 ? 16'hFFFF : w == 2'h1 ? 16'h00FF : 16'h001F;
    endfunction
    function automatic [15:0] pre(input [1:0] w, input [2:0] s);
        case (s)
            3'h1: pre = w == 2'h2 ? 16'h6363 : 16'h0012;
            3'h2: pre = w == 2'h2 ? 16'hA671 : w == 2'h1 ? 16'h00BF : 16'h0000;
            3'h3: pre = w == 2'h2 ? 16'hFFFE : w == 2'h1 ? 16'h00FD : 16'h0000;
            3'h6: pre = user_preset;
            3'h7: pre = 16'hFFFF;
            default: pre = 16'h0000;
        endcase
        pre = pre & msk(w);
    endfunction
    function automatic [15:0] crc(input [1:0] w, input [15:0] c, input [7:0] d);
        int i;
        logic fb;
        for (i = 7; i >= 0; i--) begin
            fb = d[i] ^ c[nb(w) - 1];
            c = (c << 1) ^ (fb ? (w == 2'h2 ? 16'h1021 : w == 2'h1 ? 16'h001D : 16'h0009) : 16'h0000);
        end
        crc = c & msk(w);
    endfunction

    task chk8(input string nm, input [7:0] e, input [7:0] g);
        compares++;
        if (e !== g) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task chk1(input string nm, input logic e, input logic g);
        compares++;
        if (e !== g) begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask
    task results;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task wr_reg(input [7:0] a, input [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input [7:0] a, input [7:0] e);
        rq.push_back(e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask

    // Oldest note is matched as each result appears
    always @(posedge clk) begin
        rd_q <= rd;
        if (rd_q)
            chk8("rdata", rq.size() ? rq.pop_front() : 8'hXX, rdata);
        if (tx_crc_valid)
            chk1("tx_crc_bit", txq.size() ? txq.pop_front() : 1'bx, tx_crc_bit);
        if (rx_check_done)
            chk1("rx_crc_error", eq.size() ? eq.pop_front() : 1'bx, rx_crc_error);
        if (rx_fifo_valid)
            chk1("rx_fifo_bit", fq.size() ? fq.pop_front() : 1'bx, rx_fifo_bit);
    end

    task tx_frame(input [1:0] w, input [2:0] s, input en, input inv);
        logic [15:0] c;
        logic [7:0]  d;
        int          i;
        rnd = lfsr(rnd);
        d = rnd;
        wr_reg(8'h2C, {1'b1, s, w, inv, en});
        rd_reg(8'h2C, {1'b0, s, w, inv, en});
        c = crc(w, pre(w, s), d) ^ (inv ? msk(w) : 16'h0000);
        for (i = nb(w) - 1; i >= 0 && en; i--)
            txq.push_back(c[i]);
        @(posedge clk);
        tx_frame_start <= 1'b1;
        for (i = 7; i >= 0; i--) begin
            @(posedge clk);
            tx_frame_start <= 1'b0;
            tx_bit_valid <= 1'b1;
            tx_bit <= d[i];
        end
        @(posedge clk);
        tx_bit_valid <= 1'b0;
        tx_bit <= ~d[0];
        tx_frame_end <= 1'b1;
        @(posedge clk);
        tx_frame_end <= 1'b0;
        for (i = 0; i < 300 && tx_crc_done !== 1'b1; i++)
            @(posedge clk);
        chk1("tx_pending", 1'b0, i == 300 || txq.size() != 0);
        if (i == 300)
            results;
    endtask
    // Flags: bit 0 check, 1 invert, 2 to fifo, 3 corrupt
    task rx_frame(input [1:0] w, input [2:0] s, input [3:0] f);
        logic [15:0] c;
        logic [23:0] fr;
        int          i;
        rnd = lfsr(rnd);
        c = crc(w, pre(w, s), rnd);
        fr = ({16'h0000, rnd} << nb(w)) | {8'h00, c ^ (f[1] ? msk(w) : 16'h0000) ^ {15'h0, f[3]}};
        wr_reg(8'h2D, {f[2], s, w, f[1:0]});
        for (i = nb(w) - 1; i >= 0 && f[2]; i--)
            fq.push_back(fr[i]);
        eq.push_back(f[0] & f[3]);
        p_u.send(fr, 8 + nb(w), nb(w));
        repeat (2) @(posedge clk);
        chk1("rx_pending", 1'b0, eq.size() != 0 || fq.size() != 0);
        rd_reg(8'h43, c[7:0]);
        rd_reg(8'h44, c[15:8]);
    endtask

    initial begin
        int w;
        int s;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rd_reg(8'h2D, 8'h00);
        rd_reg(8'h50, 8'h00);
        wr_reg(8'h41, 8'h07);
        for (w = 0; w < 3; w++)
            for (s = 0; s < 8; s++) begin
                rnd = lfsr(rnd);
                slow <= rnd[5];
                user_preset <= {rnd, ~rnd};
                tx_frame(w[1:0], s[2:0] | {s[2], 1'b0}, 1'b1, rnd[0]);
                rx_frame(w[1:0], s[2:0] | {s[2], 1'b0}, {rnd[4], rnd[3] | (w == 0), rnd[2:1]});
            end
        tx_frame(2'h2, 3'h7, 1'b0, 1'b0);
        wr_reg(8'h42, 8'h07);
        tx_frame(2'h0, 3'h0, 1'b0, 1'b0);
        rd_reg(8'h40, 8'h01);
        chk1("irq", 1'b1, irq);
        wr_reg(8'h41, 8'h00);
        repeat (2) @(posedge clk);
        chk1("irq", 1'b0, irq);
        wr_reg(8'h42, 8'h01);
        rd_reg(8'h40, 8'h00);
        rd_reg(8'h42, 8'h00);
        repeat (3) @(posedge clk);
        results;
    end
endmodule
